// file: verilog/ncr_pkg.sv
// package: register map, field positions and reset values of the oscillator control block
`default_nettype none
package ncr_pkg;
    // apb word offsets (byte addresses)
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;  // oscillator_control
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;  // sticky event status, read only
    localparam logic [7:0] ADDR_IRQ_ENA   = 8'h08;  // interrupt enable
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h0C;  // write one to clear, reads zero
    localparam logic [7:0] ADDR_INCREMENT = 8'h10;  // phase increment
    localparam logic [7:0] ADDR_PULSE_W   = 8'h14;  // pulse width in clocks minus one
    // control field positions
    localparam int BIT_RUN_ENABLE  = 7;
    localparam int BIT_PIN_DRIVE   = 6;
    localparam int BIT_OUT_LEVEL   = 5;
    localparam int BIT_POLARITY    = 4;
    localparam int BIT_PULSE_MODE  = 0;
    // writable bits of the control register; bits 5 and 3-1 excluded
    localparam logic [7:0] CONTROL_WMASK = 8'hD1;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // event bits
    localparam int EVT_OVERFLOW   = 0;
    localparam int EVT_TRANSITION = 1;
    localparam int EVT_WIDTH      = 2;
    localparam logic [1:0] EVT_RESET = 2'h0;
    // core sizes
    localparam int ACC_WIDTH   = 20;
    localparam int INC_WIDTH   = 16;
    localparam int PW_WIDTH    = 8;
    localparam logic [15:0] INC_RESET = 16'h0001;
    localparam logic [7:0]  PW_RESET  = 8'h00;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// file: verilog/ncr_core.sv
// oscillator core: accumulator, toggle or pulse output stage
`default_nettype none
module ncr_core #(
    parameter int ACC_W = ncr_pkg::ACC_WIDTH,
    parameter int INC_W = ncr_pkg::INC_WIDTH,
    parameter int PW_W  = ncr_pkg::PW_WIDTH
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             reset_n_i,
    // control
    input  wire logic             run_i,
    input  wire logic             pulse_mode_i,
    input  wire logic [INC_W-1:0] increment_i,
    input  wire logic [PW_W-1:0]  pulse_width_i,
    // outputs
    output logic                  raw_o,
    output logic                  overflow_o
);
    logic [ACC_W-1:0] acc_q;      // phase accumulator
    logic [ACC_W:0]   sum;        // sum with carry
    logic [PW_W-1:0]  pcnt_q;     // pulse remaining count
    logic             raw_q;      // output before polarity
    logic             raw_d;

    assign sum        = {1'b0, acc_q} + {{(ACC_W+1-INC_W){1'b0}}, increment_i};
    assign overflow_o = run_i & sum[ACC_W];
    // gated at once so the level never lags a disable by one clock
    assign raw_o      = raw_q & run_i;

    // next raw level per mode
    always_comb
    begin
        raw_d = raw_q;
        if (!run_i)
            raw_d = 1'b0;
        else if (!pulse_mode_i)
        begin
            if (overflow_o)
                raw_d = ~raw_q;
        end
        else if (overflow_o)
            raw_d = 1'b1;
        else if (pcnt_q == '0)
            raw_d = 1'b0;
    end

    // accumulator and pulse counter; halted and cleared while disabled
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || !run_i)
        begin
            acc_q  <= '0;
            pcnt_q <= '0;
            raw_q  <= 1'b0;
        end
        else
        begin
            acc_q <= sum[ACC_W-1:0];
            raw_q <= raw_d;
            if (overflow_o)
                pcnt_q <= pulse_width_i;
            else if (pcnt_q != '0)
                pcnt_q <= pcnt_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: verilog/ncr_top.sv
// oscillator control register bank with apb slave, interrupts and output stage
`default_nettype none
// Summary of operation
// - run oscillator only while run_enable set
// - pin carries output only with pin_drive_enable
// - output_level bit reads present output
// - polarity bit sets active level, last stage
// - bits 3-1 ignore writes, read zero
// - pulse_mode_select one selects pulse mode
// - toggle mode inverts output each overflow
// - polarity change while running raises transition interrupt
module ncr_top #(
    parameter int INC_W = ncr_pkg::INC_WIDTH,
    parameter int PW_W  = ncr_pkg::PW_WIDTH
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // oscillator outputs
    output logic             nco_out_o,
    output logic             pin_out_o,
    output logic             pin_oe_o,
    // interrupt
    output logic             irq_o
);
    logic [7:0]                     ctrl_q;    // writable control bits
    logic [ncr_pkg::EVT_WIDTH-1:0]  stat_q;    // sticky events
    logic [ncr_pkg::EVT_WIDTH-1:0]  stat_d;
    logic [ncr_pkg::EVT_WIDTH-1:0]  ena_q;     // interrupt enables
    logic [INC_W-1:0]               inc_q;     // increment value
    logic [PW_W-1:0]                pw_q;      // pulse width
    logic [31:0]                    prdata_q;  // registered read data
    logic                           out_q;     // registered polarised output
    logic                           raw;
    logic                           ovf;

    // bus decode
    wire access   = psel_i & penable_i;
    wire wr       = access & pwrite_i;
    // read data captured in the setup cycle so it stands through the access cycle
    wire rd       = psel_i & ~penable_i & ~pwrite_i;
    wire hit_ctl  = paddr_i == ncr_pkg::ADDR_CONTROL;
    wire hit_stat = paddr_i == ncr_pkg::ADDR_IRQ_STAT;
    wire hit_ena  = paddr_i == ncr_pkg::ADDR_IRQ_ENA;
    wire hit_clr  = paddr_i == ncr_pkg::ADDR_IRQ_CLR;
    wire hit_inc  = paddr_i == ncr_pkg::ADDR_INCREMENT;
    wire hit_pw   = paddr_i == ncr_pkg::ADDR_PULSE_W;
    wire mapped   = hit_ctl | hit_stat | hit_ena | hit_clr | hit_inc | hit_pw;

    // control fields
    wire run_en   = ctrl_q[ncr_pkg::BIT_RUN_ENABLE];
    wire pin_en   = ctrl_q[ncr_pkg::BIT_PIN_DRIVE];
    wire pol      = ctrl_q[ncr_pkg::BIT_POLARITY];
    wire pmode    = ctrl_q[ncr_pkg::BIT_PULSE_MODE];

    // polarity is the last stage: active-low inverts the raw level
    wire out_d    = pol ? raw : ~raw;

    // control read view with live level in bit 5, unused bits zero
    wire [7:0] ctrl_view = (ctrl_q & ncr_pkg::CONTROL_WMASK)
                         | (8'(out_q) << ncr_pkg::BIT_OUT_LEVEL);

    // read mux; unmapped and clear register read zero
    wire [31:0] rd_mux =
        hit_ctl  ? {24'h00_0000, ctrl_view} :
        hit_stat ? {30'h0000_0000, stat_q} :
        hit_ena  ? {30'h0000_0000, ena_q} :
        hit_inc  ? {16'h0000, inc_q} :
        hit_pw   ? {24'h00_0000, pw_q} : ncr_pkg::DATA_ZERO;

    // events: overflow and any output transition while running, incl. polarity flips
    wire evt_ovf  = ovf;
    wire evt_tr   = run_en & (out_d != out_q);
    wire [ncr_pkg::EVT_WIDTH-1:0] evt = {evt_tr, evt_ovf};
    wire [ncr_pkg::EVT_WIDTH-1:0] clr = (wr & hit_clr) ?
                                        pwdata_i[ncr_pkg::EVT_WIDTH-1:0] : '0;

    // set wins over a clear in the same cycle
    assign stat_d = (stat_q & ~clr) | evt;

    // zero-wait slave: answers in the access cycle
    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~mapped;
    assign prdata_o  = prdata_q;
    assign nco_out_o = out_q;
    assign pin_out_o = out_q & pin_en;
    assign pin_oe_o  = pin_en;
    assign irq_o     = |(stat_q & ena_q);

    // control register; only masked bits take writes
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
            ctrl_q <= ncr_pkg::CONTROL_RESET;
        else if (wr && hit_ctl)
            ctrl_q <= pwdata_i[7:0] & ncr_pkg::CONTROL_WMASK;
    end

    // interrupt enable, increment and pulse width registers
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            ena_q <= ncr_pkg::EVT_RESET;
            inc_q <= ncr_pkg::INC_RESET;
            pw_q  <= ncr_pkg::PW_RESET;
        end
        else if (wr)
        begin
            if (hit_ena)
                ena_q <= pwdata_i[ncr_pkg::EVT_WIDTH-1:0];
            if (hit_inc)
                inc_q <= pwdata_i[INC_W-1:0];
            if (hit_pw)
                pw_q <= pwdata_i[PW_W-1:0];
        end
    end

    // status, output level and read data
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            stat_q   <= ncr_pkg::EVT_RESET;
            out_q    <= 1'b1;            // inactive level of active-low
            prdata_q <= ncr_pkg::DATA_ZERO;
        end
        else
        begin
            stat_q <= stat_d;
            out_q  <= out_d;
            if (rd)
                prdata_q <= rd_mux;
        end
    end

    // oscillator core
    ncr_core #(
        .INC_W (INC_W),
        .PW_W  (PW_W)
    ) u_core (
        .mclk_i        (mclk_i),
        .reset_n_i     (reset_n_i),
        .run_i         (run_en),
        .pulse_mode_i  (pmode),
        .increment_i   (inc_q),
        .pulse_width_i (pw_q),
        .raw_o         (raw),
        .overflow_o    (ovf)
    );

    // checks
    property p_run_gate;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !run_en |=> (out_q == ~pol) || $changed(pol);
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("output active while disabled");

    property p_pin_gate;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !pin_en |-> !pin_oe_o && !pin_out_o;
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("pin driven while disabled");

    property p_level_read;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rd && hit_ctl) |=> prdata_o[ncr_pkg::BIT_OUT_LEVEL] == $past(out_q);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level bit mismatch");

    property p_polarity;
        @(posedge mclk_i) disable iff (!reset_n_i)
        1'b1 |=> out_q == ($past(pol) ? $past(raw) : ~$past(raw));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity stage wrong");

    property p_unused_zero;
        @(posedge mclk_i) disable iff (!reset_n_i)
        ctrl_q[3:1] == 3'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

    sequence s_toggle_ovf;
        run_en && !pmode && ovf && $stable(pol);
    endsequence
    property p_toggle;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_toggle_ovf ##1 (run_en && $stable(pol)) |=> out_q != $past(out_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_pulse_start;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (run_en && pmode && ovf) ##1 (run_en && pmode) |-> raw;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse not started");

    property p_pol_irq;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (run_en && out_d != out_q) |=> stat_q[ncr_pkg::EVT_TRANSITION];
    endproperty
    a_pol_irq: assert property (p_pol_irq) else $error("transition event lost");

    property p_reset_clear;
        @(posedge mclk_i)
        !reset_n_i |=> ctrl_q == ncr_pkg::CONTROL_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("control not cleared");

    // pin follows the polarised output while drive is on
    property p_pin_follow;
        @(posedge mclk_i) disable iff (!reset_n_i)
        pin_en |-> pin_oe_o && (pin_out_o == nco_out_o);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin not following output");

    // no overflow reaches status while the oscillator is halted
    property p_no_ovf_idle;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !run_en |-> !ovf;
    endproperty
    a_no_ovf_idle: assert property (p_no_ovf_idle) else $error("overflow while disabled");

    // a fresh enable starts from a low raw level
    property p_run_start;
        @(posedge mclk_i) disable iff (!reset_n_i)
        $rose(run_en) |-> !raw;
    endproperty
    a_run_start: assert property (p_run_start) else $error("raw high at enable");

    // toggle mode holds its level between overflows
    property p_toggle_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (run_en && !pmode && !ovf) |=> !run_en || pmode || $stable(raw);
    endproperty
    a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved early");

    // pulse with nonzero width is still active one clock after it starts
    sequence s_pulse_begin;
        run_en && pmode && ovf && (pw_q != '0);
    endsequence
    sequence s_pulse_run;
        run_en && pmode && !ovf && $stable(pw_q);
    endsequence
    property p_pulse_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_pulse_begin ##1 s_pulse_run |=> !run_en || raw;
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("pulse ended early");

    // a transition event beats a clear written in the same cycle
    property p_set_wins;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (wr && hit_clr && evt_tr) |=> stat_q[ncr_pkg::EVT_TRANSITION];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat event");

    // control write keeps only the writable bits
    property p_ctrl_write;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (wr && hit_ctl) |=> ctrl_q == ($past(pwdata_i[7:0]) & ncr_pkg::CONTROL_WMASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");

    // unused control bits read back as zero
    property p_read_unused;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rd && hit_ctl) |=> prdata_o[3:1] == 3'h0;
    endproperty
    a_read_unused: assert property (p_read_unused) else $error("unused bits read set");

    // reset leaves output idle, pin off and interrupt low
    property p_reset_out;
        @(posedge mclk_i)
        !reset_n_i |=> nco_out_o && !pin_oe_o && !pin_out_o && !irq_o;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");

    // masked events never raise the line
    property p_irq_masked;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ena_q == '0) |-> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised");
endmodule
`default_nettype wire

// file: dv/ncr_top_tb.sv
// testbench: apb-driven scenarios for the oscillator control register bank
`default_nettype none
module ncr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and apb drive
    logic        mclk_i    = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0000_0000;
    // design outputs
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        nco_out_o;
    logic        pin_out_o;
    logic        pin_oe_o;
    logic        irq_o;
    // bookkeeping
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          cyc;
    logic [31:0] rd;
    logic        err;

    // 25 MHz clock
    always #20 mclk_i = ~mclk_i;

    ncr_top dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .nco_out_o(nco_out_o),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o)
    );

    // single exit point of the run
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; response and read data taken at the completing edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge mclk_i);
            if (pready_o === 1'b1)
                break;
        end
        if (n == 20)
        begin
            num_errors++;
            finish_test();
        end
        err = pslverr_o;
        rd = prdata_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // edges until the oscillator output changes, capped at lim
    task automatic wait_chg(input int lim);
        logic v;
        v = nco_out_o;
        for (cyc = 1; cyc < lim; cyc++)
        begin
            @(posedge mclk_i);
            if (nco_out_o !== v)
                break;
        end
    endtask

    // reset state, field access and pin path
    task automatic t_fields;
        apb(1'b0, ncr_pkg::ADDR_CONTROL, 32'h0000_0000);
        check(rd, 32'h0000_0020);
        check({pin_oe_o, pin_out_o, irq_o, nco_out_o}, 4'h1);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_005E);
        apb(1'b0, ncr_pkg::ADDR_CONTROL, 32'h0000_0000);
        check(rd, 32'h0000_0050);
        check({pin_oe_o, pin_out_o}, 2'h2);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_004E);
        apb(1'b0, ncr_pkg::ADDR_CONTROL, 32'h0000_0000);
        check(rd, 32'h0000_0060);
        check(pin_out_o, 1'b1);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0000);
        check(pin_out_o, 1'b0);
    endtask

    // toggle mode period with increment 0x8000: 32 clocks per overflow
    task automatic t_toggle;
        apb(1'b1, ncr_pkg::ADDR_INCREMENT, 32'h0000_8000);
        apb(1'b1, ncr_pkg::ADDR_IRQ_CLR, 32'h0000_0003);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0090);
        wait_chg(100);
        wait_chg(100);
        check(cyc, 32);
        wait_chg(100);
        check(cyc, 32);
        apb(1'b0, ncr_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        check(rd[0], 1'b1);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0010);
        repeat (3) @(posedge mclk_i);
        wait_chg(100);
        check(cyc, 100);
    endtask

    // pulse mode: width register 3 gives four active clocks
    task automatic t_pulse;
        apb(1'b1, ncr_pkg::ADDR_PULSE_W, 32'h0000_0003);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0091);
        wait_chg(100);
        if (nco_out_o !== 1'b1)
            wait_chg(100);
        wait_chg(100);
        check(cyc, 4);
        wait_chg(100);
        check(cyc, 28);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0000);
    endtask

    // polarity flip raises the transition event; enable masks the line
    task automatic t_irq;
        apb(1'b1, ncr_pkg::ADDR_INCREMENT, 32'h0000_0001);
        apb(1'b1, ncr_pkg::ADDR_IRQ_CLR, 32'h0000_0003);
        apb(1'b1, ncr_pkg::ADDR_IRQ_ENA, 32'h0000_0002);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0080);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0090);
        apb(1'b0, ncr_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        check(rd, 32'h0000_0002);
        check(irq_o, 1'b1);
        apb(1'b1, ncr_pkg::ADDR_IRQ_CLR, 32'h0000_0002);
        check(irq_o, 1'b0);
        apb(1'b1, ncr_pkg::ADDR_IRQ_ENA, 32'h0000_0000);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0080);
        apb(1'b0, ncr_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        check(rd, 32'h0000_0002);
        check(irq_o, 1'b0);
        apb(1'b0, ncr_pkg::ADDR_IRQ_CLR, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b1, ncr_pkg::ADDR_CONTROL, 32'h0000_0000);
    endtask

    // unmapped address is refused with an error and reads zero
    task automatic t_unmapped;
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        check(err, 1'b1);
        apb(1'b0, 8'h18, 32'h0000_0000);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
    endtask

    // main sequence: reset held 16 clocks, then every scenario once
    initial
    begin
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        t_fields();
        t_toggle();
        t_pulse();
        t_irq();
        t_unmapped();
        finish_test();
    end
endmodule
`default_nettype wire
